// ===== hdl/ppg_pkg.sv
package ppg_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_MODE       = 8'h00;
    localparam logic [7:0] OFS_CTRL       = 8'h04;
    localparam logic [7:0] OFS_PERIOD_LO  = 8'h08;
    localparam logic [7:0] OFS_PERIOD_HI  = 8'h0C;
    localparam logic [7:0] OFS_COMPARE_LO = 8'h10;
    localparam logic [7:0] OFS_COMPARE_HI = 8'h14;
    localparam logic [7:0] OFS_STATUS     = 8'h18;

    // ----------------------------------------------------------------
    // Field layouts and reset values
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] clock_select_field;
        logic [2:0] mode_select_field;
    } mode_t;

    typedef struct packed {
        logic [1:0] filter_select_field;
        logic       double_buffer_enable;
        logic       overflow_enable;
        logic       output_initial_level;
        logic       one_shot_select;
        logic       run_bit;
    } ctrl_t;

    localparam logic [2:0]  MODE_PPG        = 3'h3;
    localparam mode_t       MODE_RESET      = 6'h00;
    localparam ctrl_t       CTRL_RESET      = 7'h00;
    localparam logic [15:0] REG16_RESET     = 16'hFFFF;
    localparam logic [7:0]  TEMP_RESET      = 8'h00;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // ----------------------------------------------------------------
    // Filter sampling intervals in gear-clock periods
    // ----------------------------------------------------------------
    localparam logic [1:0]  NC_OFF          = 2'h0;
    localparam logic [1:0]  NC_DIV2         = 2'h1;
    localparam logic [1:0]  NC_DIV4         = 2'h2;
    localparam logic [1:0]  NC_DIV256       = 2'h3;
    localparam logic [7:0]  NC_MASK_2       = 8'h01;
    localparam logic [7:0]  NC_MASK_4       = 8'h03;
    localparam logic [7:0]  NC_MASK_256     = 8'hFF;

endpackage : ppg_pkg

// ===== hdl/timer_ppg_noise_filter.sv
// Notes on behaviour
// - Mode select value 011 enables pulse output, clocked by the clock-select tick.
// - Idle pulse output equals the initial level bit.
// - Run bit starts counting; mode, overflow-enable, initial level locked while running.
// - Counter equal to compare drives output opposite to initial level.
// - Counter equal to period restores initial level and pulses interrupt request.
// - One-shot set: period match clears run bit and stops.
// - One-shot clear: period match zeroes counter, generation continues.
// - Run bit low, by software or one-shot, restores initial level.
// - One-shot bit writable while running, takes effect at next period match.
// - Double buffer on: running writes become active at next period match.
// - Double buffer off: writes act at once; counter wraps if passed.
// - Low byte goes to temp buffer; high byte write commits both.
// - Double buffer on: reads return buffered value, not active value.
// - Stopped writes update active registers and buffer together.
// - Filter output changes only after three equal consecutive samples.
// - Filter select nonzero enables filter regardless of run; 00 bypasses.
// - Filter select writes ignored while running.
// - Filter intervals: 01 two, 10 four, 11 256 gear-clock periods.
// - Low-frequency mode: 11 samples at low clock/2; 01, 10 block input.
module timer_ppg_noise_filter (
    input  wire logic              I_REF_CLK,
    input  wire logic              I_RESET,
    input  wire logic [7:0]        I_AWADDR,
    input  wire logic              I_AWVALID,
    output logic                   O_AWREADY,
    input  wire logic [31:0]       I_WDATA,
    input  wire logic [3:0]        I_WSTRB,
    input  wire logic              I_WVALID,
    output logic                   O_WREADY,
    output logic [1:0]             O_BRESP,
    output logic                   O_BVALID,
    input  wire logic              I_BREADY,
    input  wire logic [7:0]        I_ARADDR,
    input  wire logic              I_ARVALID,
    output logic                   O_ARREADY,
    output logic [31:0]            O_RDATA,
    output logic [1:0]             O_RRESP,
    output logic                   O_RVALID,
    input  wire logic              I_RREADY,
    input  wire logic              I_EXTERNAL_TIMER_INPUT,
    input  wire logic              I_LOW_FREQ_CLOCK,
    input  wire logic              I_LOW_FREQ_MODE,
    output logic                   O_PULSE_OUTPUT_PIN,
    output logic                   O_TIMER_INTERRUPT_REQUEST,
    output logic                   O_FILTERED_INPUT
);
    import ppg_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    mode_t        mode_reg;
    ctrl_t        ctrl_reg;
    logic [7:0]   temp_reg;
    logic [15:0]  period_act_reg;
    logic [15:0]  period_buf_reg;
    logic [15:0]  compare_act_reg;
    logic [15:0]  compare_buf_reg;
    logic [15:0]  count_reg;
    logic [10:0]  presc_reg;
    logic         pulse_reg;
    logic         irq_reg;
    logic [7:0]   aw_addr_reg;
    logic         aw_got_reg;
    logic [31:0]  w_data_reg;
    logic [3:0]   w_strb_reg;
    logic         w_got_reg;
    logic         bvalid_reg;
    logic [1:0]   bresp_reg;
    logic         rvalid_reg;
    logic [1:0]   rresp_reg;
    logic [31:0]  rdata_reg;
    logic [1:0]   ext_sync_reg;
    logic [2:0]   lf_sync_reg;
    logic [1:0]   mode_sync_reg;
    logic         lf_half_reg;
    logic [7:0]   nc_div_reg;
    logic [2:0]   samp_reg;
    logic         filt_reg;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire         wr_en       = aw_got_reg && w_got_reg && !bvalid_reg;
    wire         wr_lane0    = wr_en && w_strb_reg[0];
    wire         wr_mode     = wr_lane0 && (aw_addr_reg == OFS_MODE);
    wire         wr_ctrl     = wr_lane0 && (aw_addr_reg == OFS_CTRL);
    wire         wr_per_lo   = wr_lane0 && (aw_addr_reg == OFS_PERIOD_LO);
    wire         wr_per_hi   = wr_lane0 && (aw_addr_reg == OFS_PERIOD_HI);
    wire         wr_cmp_lo   = wr_lane0 && (aw_addr_reg == OFS_COMPARE_LO);
    wire         wr_cmp_hi   = wr_lane0 && (aw_addr_reg == OFS_COMPARE_HI);
    wire         aw_mapped   = (aw_addr_reg <= OFS_STATUS) && (aw_addr_reg[1:0] == 2'h0);
    wire         ar_mapped   = (I_ARADDR <= OFS_STATUS) && (I_ARADDR[1:0] == 2'h0);
    wire         ar_take     = I_ARVALID && !rvalid_reg;
    wire [15:0]  wr_value    = {w_data_reg[7:0], temp_reg};
    wire ctrl_t  wr_ctrl_val = ctrl_t'(w_data_reg[6:0]);

    // Double buffer on: reads see the last written value
    wire [15:0]  per_read    = ctrl_reg.double_buffer_enable ? period_buf_reg
                                                              : period_act_reg;
    wire [15:0]  cmp_read    = ctrl_reg.double_buffer_enable ? compare_buf_reg
                                                              : compare_act_reg;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (I_ARADDR)
            OFS_MODE:       rd_mux = {26'h0, mode_reg};
            OFS_CTRL:       rd_mux = {25'h0, ctrl_reg};
            OFS_PERIOD_LO:  rd_mux = {24'h0, per_read[7:0]};
            OFS_PERIOD_HI:  rd_mux = {24'h0, per_read[15:8]};
            OFS_COMPARE_LO: rd_mux = {24'h0, cmp_read[7:0]};
            OFS_COMPARE_HI: rd_mux = {24'h0, cmp_read[15:8]};
            OFS_STATUS:     rd_mux = {14'h0, filt_reg, pulse_reg, count_reg};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    assign O_AWREADY = !aw_got_reg && !bvalid_reg;
    assign O_WREADY  = !w_got_reg && !bvalid_reg;
    assign O_ARREADY = !rvalid_reg;
    assign O_BVALID  = bvalid_reg;
    assign O_BRESP   = bresp_reg;
    assign O_RVALID  = rvalid_reg;
    assign O_RRESP   = rresp_reg;
    assign O_RDATA   = rdata_reg;

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            aw_got_reg  <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_got_reg   <= 1'b0;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            if (I_AWVALID && O_AWREADY) begin
                aw_got_reg  <= 1'b1;
                aw_addr_reg <= I_AWADDR;
            end
            if (I_WVALID && O_WREADY) begin
                w_got_reg  <= 1'b1;
                w_data_reg <= I_WDATA;
                w_strb_reg <= I_WSTRB;
            end
            if (wr_en) begin
                aw_got_reg <= 1'b0;
                w_got_reg  <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg  <= aw_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && I_BREADY) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= ar_mapped ? RESP_OKAY : RESP_SLVERR;
            rdata_reg  <= rd_mux;
        end else if (rvalid_reg && I_RREADY) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Clock select prescaler and match detection
    // ----------------------------------------------------------------
    logic [10:0] presc_mask;
    always_comb begin
        unique case (mode_reg.clock_select_field)
            3'h0: presc_mask = 11'h7FF;
            3'h1: presc_mask = 11'h3FF;
            3'h2: presc_mask = 11'h0FF;
            3'h3: presc_mask = 11'h03F;
            3'h4: presc_mask = 11'h00F;
            3'h5: presc_mask = 11'h003;
            3'h6: presc_mask = 11'h001;
            3'h7: presc_mask = 11'h000;
        endcase
    end

    wire running    = ctrl_reg.run_bit;
    wire ppg_mode   = (mode_reg.mode_select_field == MODE_PPG);
    wire clk_tick   = ((presc_reg & presc_mask) == presc_mask);
    wire count_tick = running && ppg_mode && clk_tick;
    wire match_per  = count_tick && (count_reg == period_act_reg);
    wire match_cmp  = count_tick && (count_reg == compare_act_reg);
    wire init_level = ctrl_reg.output_initial_level;

    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            presc_reg <= 11'h000;
        end else begin
            presc_reg <= presc_reg + 11'h001;
        end
    end

    // ----------------------------------------------------------------
    // Mode and control registers
    // ----------------------------------------------------------------
    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            mode_reg <= MODE_RESET;
            ctrl_reg <= CTRL_RESET;
        end else begin
            if (wr_mode && !running) begin
                mode_reg <= mode_t'(w_data_reg[5:0]);
            end
            if (wr_ctrl) begin
                ctrl_reg.run_bit              <= wr_ctrl_val.run_bit;
                ctrl_reg.one_shot_select      <= wr_ctrl_val.one_shot_select;
                ctrl_reg.double_buffer_enable <= wr_ctrl_val.double_buffer_enable;
                if (!running) begin
                    ctrl_reg.output_initial_level <= wr_ctrl_val.output_initial_level;
                    ctrl_reg.overflow_enable      <= wr_ctrl_val.overflow_enable;
                    ctrl_reg.filter_select_field  <= wr_ctrl_val.filter_select_field;
                end
            end else if (match_per && ctrl_reg.one_shot_select) begin
                ctrl_reg.run_bit <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Period and compare with temp and double buffer
    // ----------------------------------------------------------------
    wire direct_load = !running || !ctrl_reg.double_buffer_enable;

    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            temp_reg        <= TEMP_RESET;
            period_act_reg  <= REG16_RESET;
            period_buf_reg  <= REG16_RESET;
            compare_act_reg <= REG16_RESET;
            compare_buf_reg <= REG16_RESET;
        end else begin
            if (wr_per_lo || wr_cmp_lo) begin
                temp_reg <= w_data_reg[7:0];
            end
            // Pending values move in at the period match
            if (match_per && ctrl_reg.double_buffer_enable) begin
                period_act_reg  <= period_buf_reg;
                compare_act_reg <= compare_buf_reg;
            end
            if (wr_per_hi) begin
                period_buf_reg <= wr_value;
                if (direct_load) begin
                    period_act_reg <= wr_value;
                end
            end
            if (wr_cmp_hi) begin
                compare_buf_reg <= wr_value;
                if (direct_load) begin
                    compare_act_reg <= wr_value;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Up counter and pulse output
    // ----------------------------------------------------------------
    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            count_reg <= 16'h0000;
            pulse_reg <= 1'b0;
            irq_reg   <= 1'b0;
        end else begin
            irq_reg <= match_per;
            if (!running) begin
                count_reg <= 16'h0000;
                pulse_reg <= init_level;
            end else begin
                if (match_per) begin
                    count_reg <= 16'h0000;
                end else if (count_tick) begin
                    // Natural 16-bit wrap covers a passed match value
                    count_reg <= count_reg + 16'h0001;
                end
                if (match_per) begin
                    pulse_reg <= init_level;
                end else if (match_cmp) begin
                    pulse_reg <= !init_level;
                end
            end
        end
    end

    assign O_PULSE_OUTPUT_PIN        = pulse_reg;
    assign O_TIMER_INTERRUPT_REQUEST = irq_reg;

    // ----------------------------------------------------------------
    // Noise canceller
    // ----------------------------------------------------------------
    // Third stage only feeds the edge detector, never the first stage
    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            ext_sync_reg  <= 2'h0;
            lf_sync_reg   <= 3'h0;
            mode_sync_reg <= 2'h0;
            lf_half_reg   <= 1'b0;
            nc_div_reg    <= 8'h00;
        end else begin
            ext_sync_reg  <= {ext_sync_reg[0], I_EXTERNAL_TIMER_INPUT};
            lf_sync_reg   <= {lf_sync_reg[1:0], I_LOW_FREQ_CLOCK};
            mode_sync_reg <= {mode_sync_reg[0], I_LOW_FREQ_MODE};
            nc_div_reg    <= nc_div_reg + 8'h01;
            if (lf_sync_reg[1] && !lf_sync_reg[2]) begin
                lf_half_reg <= !lf_half_reg;
            end
        end
    end

    wire ext_in   = ext_sync_reg[1];
    wire slow     = mode_sync_reg[1];
    wire lf_tick  = lf_sync_reg[1] && !lf_sync_reg[2] && lf_half_reg;
    wire [1:0] nc_sel = ctrl_reg.filter_select_field;
    wire nc_on    = (nc_sel != NC_OFF);
    wire nc_block = slow && ((nc_sel == NC_DIV2) || (nc_sel == NC_DIV4));

    logic samp_tick;
    always_comb begin
        unique case (nc_sel)
            NC_DIV2:   samp_tick = ((nc_div_reg & NC_MASK_2) == NC_MASK_2);
            NC_DIV4:   samp_tick = ((nc_div_reg & NC_MASK_4) == NC_MASK_4);
            NC_DIV256: samp_tick = slow ? lf_tick
                                        : ((nc_div_reg & NC_MASK_256) == NC_MASK_256);
            default:   samp_tick = 1'b0;
        endcase
    end

    wire agree = (samp_reg == 3'h7) || (samp_reg == 3'h0);

    // Blocked input holds its last level rather than forcing a value
    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            samp_reg <= 3'h0;
            filt_reg <= 1'b0;
        end else if (!nc_on) begin
            samp_reg <= {3{ext_in}};
            filt_reg <= ext_in;
        end else if (!nc_block) begin
            if (samp_tick) begin
                samp_reg <= {samp_reg[1:0], ext_in};
            end
            if (agree) begin
                filt_reg <= samp_reg[0];
            end
        end
    end

    assign O_FILTERED_INPUT = filt_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RESET);

    property p_mode_lock;
        running && $past(running) |-> $stable(mode_reg);
    endproperty
    a_mode_lock: assert property (p_mode_lock) else $error("mode changed while running");

    property p_compare_flip;
        match_cmp && !match_per |=> pulse_reg == !$past(init_level) || !running;
    endproperty
    a_compare_flip: assert property (p_compare_flip) else $error("no flip at compare");

    property p_period_return;
        match_per |=> pulse_reg == $past(init_level) && irq_reg && count_reg == 16'h0000;
    endproperty
    a_period_return: assert property (p_period_return) else $error("bad period match");

    property p_one_shot_stop;
        match_per && ctrl_reg.one_shot_select && !wr_ctrl |=> !running ##1 !irq_reg;
    endproperty
    a_one_shot_stop: assert property (p_one_shot_stop) else $error("one-shot kept running");

    property p_continuous;
        match_per && !ctrl_reg.one_shot_select && !wr_ctrl |=> running && count_reg == 16'h0000;
    endproperty
    a_continuous: assert property (p_continuous) else $error("continuous mode stopped");

    property p_idle_level;
        !running && !$past(running) |-> O_PULSE_OUTPUT_PIN == $past(init_level);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle output not initial");

    property p_hold_buffered;
        running && ctrl_reg.double_buffer_enable && wr_per_hi && !match_per
            |=> $stable(period_act_reg) && period_buf_reg == $past(wr_value);
    endproperty
    a_hold_buffered: assert property (p_hold_buffered) else $error("buffered write leaked");

    property p_direct_load;
        wr_cmp_hi && direct_load |=> compare_act_reg == $past(wr_value);
    endproperty
    a_direct_load: assert property (p_direct_load) else $error("direct load missed");

    property p_temp_hold;
        wr_per_lo |=> temp_reg == $past(w_data_reg[7:0]) ##0 $stable(period_buf_reg);
    endproperty
    a_temp_hold: assert property (p_temp_hold) else $error("low byte not held");

    property p_filter_agree;
        nc_on && !nc_block && $changed(filt_reg) && $past(nc_on) |-> $past(agree);
    endproperty
    a_filter_agree: assert property (p_filter_agree) else $error("filter changed early");

    property p_filter_lock;
        running && $past(running) |-> $stable(ctrl_reg.filter_select_field);
    endproperty
    a_filter_lock: assert property (p_filter_lock) else $error("filter select changed");

    c_period_match:  cover property (match_per && !ctrl_reg.one_shot_select);
    c_one_shot_end:  cover property (match_per && ctrl_reg.one_shot_select);
    c_buffered_load: cover property (match_per && ctrl_reg.double_buffer_enable);
    c_filter_flip:   cover property (nc_on && $changed(filt_reg));

endmodule : timer_ppg_noise_filter

// ===== verif/ppg_far_side.sv
module ppg_far_side (
    input  wire logic i_clk,
    input  wire logic i_level,
    input  wire logic i_pulse,
    output logic      o_ext,
    output int        o_rises
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_q = 1'b0;
    int   rise_q = 0;
    // Pin follows the commanded level, glitches included, so no filtering is lent
    assign o_ext   = i_level;
    assign o_rises = rise_q;
    always @(posedge i_clk) begin
        last_q <= i_pulse;
        if (i_pulse && !last_q) begin
            rise_q <= rise_q + 1;
        end
    end
endmodule : ppg_far_side

// ===== verif/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ppg_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, lvl = 1'b0, lf = 1'b0, slow = 1'b0, init, cur;
    logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdata, rd;
    logic [1:0]  bresp, rresp, rsp;
    logic        awr, wr_rdy, bv, arr, rv, pulse, irq, filt, ext;
    int          err_total = 0, total_checks = 0, p, c, f, q, iv, rises, r0;
    always #4 clk = ~clk;
    always #28 lf = ~lf;
    timer_ppg_noise_filter dut (.I_REF_CLK(clk), .I_RESET(rst), .I_AWADDR(awa),
        .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv),
        .O_WREADY(wr_rdy), .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(bry), .I_ARADDR(ara),
        .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rv),
        .I_RREADY(rry), .I_EXTERNAL_TIMER_INPUT(ext), .I_LOW_FREQ_CLOCK(lf),
        .I_LOW_FREQ_MODE(slow), .O_PULSE_OUTPUT_PIN(pulse), .O_TIMER_INTERRUPT_REQUEST(irq),
        .O_FILTERED_INPUT(filt));
    ppg_far_side far (.i_clk(clk), .i_level(lvl), .i_pulse(pulse), .o_ext(ext), .o_rises(rises));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awa <= a;
        wd  <= d;
        awv <= 1'b1;
        wv  <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_rdy) wv <= 1'b0;
        end while (!(bv && bry));
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
        end while (!(rv && rry));
        rd = rdata;
        rsp = rresp;
    endtask : rdr
    // Low byte parks in the holding buffer, high byte commits the pair
    task automatic ld(input logic [7:0] lo, input int v);
        wr(lo, {24'h0, v[7:0]});
        wr(lo + 8'h04, {24'h0, v[15:8]});
    endtask : ld
    task automatic wirq();
        do @(posedge clk); while (irq !== 1'b1);
    endtask : wirq
    // Edges from one match to the first inverted level and to the next match
    task automatic per();
        f = 0;
        q = 0;
        do begin
            @(posedge clk);
            q++;
            if (f == 0 && pulse !== init) f = q;
        end while (irq !== 1'b1);
    endtask : per
    initial begin
        repeat (50000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(72005));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdr(OFS_PERIOD_HI);
        chk(rd, 32'hFF);
        rdr(8'h40);
        chk(rsp, RESP_SLVERR);
        p = 20 + $urandom % 20;
        c = 2 + $urandom % (p - 3);
        init = 1'($urandom % 2);
        ld(OFS_PERIOD_LO, p);
        ld(OFS_COMPARE_LO, c);
        wr(OFS_CTRL, {29'h0, init, 2'b00});
        @(posedge clk);
        chk(pulse, init);
        wr(OFS_MODE, 32'h3B);
        wr(OFS_CTRL, {29'h0, init, 2'b01});
        wirq();
        r0 = rises;
        per();
        chk(f, c + 1);
        chk(rises - r0, 1);
        chk(q, p + 1);
        wr(OFS_MODE, 32'h00);
        wr(OFS_CTRL, {25'h0, 2'b10, 2'b11, ~init, 2'b01});
        rdr(OFS_MODE);
        chk(rd, 32'h3B);
        rdr(OFS_CTRL);
        chk(rd, {25'h0, 2'b00, 2'b10, init, 2'b01});
        $display("test continuous done");
        p = c + 4 + $urandom % 20;
        ld(OFS_PERIOD_LO, p);
        rdr(OFS_PERIOD_LO);
        chk(rd, {24'h0, p[7:0]});
        wirq();
        per();
        chk(q, p + 1);
        wr(OFS_CTRL, {29'h0, init, 2'b00});
        repeat (2) @(posedge clk);
        chk(pulse, init);
        wr(OFS_CTRL, {29'h0, init, 2'b01});
        wr(OFS_CTRL, {29'h0, init, 2'b11});
        wirq();
        repeat (3) @(posedge clk);
        rdr(OFS_CTRL);
        chk(rd[0], 1'b0);
        chk(pulse, init);
        $display("test one-shot done");
        cur = 1'b0;
        for (int code = 1; code < 4; code++) begin
            iv = (code == 3) ? 256 : 2 * code;
            wr(OFS_CTRL, {25'h0, 2'(code), 5'h00});
            repeat (4 * iv + 8) @(posedge clk);
            lvl <= ~cur;
            repeat (iv) @(posedge clk);
            lvl <= cur;
            repeat (4 * iv + 8) @(posedge clk);
            chk(filt, cur);
            lvl <= ~cur;
            repeat (5 * iv + 8) @(posedge clk);
            chk(filt, !cur);
            cur = ~cur;
        end
        slow <= 1'b1;
        wr(OFS_CTRL, 32'h20);
        lvl <= ~cur;
        repeat (60) @(posedge clk);
        chk(filt, cur);
        // Slow clock halved samples far sooner than the 256-cycle gear rate
        wr(OFS_CTRL, 32'h60);
        repeat (100) @(posedge clk);
        chk(filt, !cur);
        $display("test filter done");
        tally_and_finish();
    end
endmodule : testbench
